// ---- logic/pfc_host.sv ----
// Purpose: host controller driving an asynchronous parallel nor flash
// Assumes: one request at a time, word mode, elevated voltages via switch enables
// Notes: data pins are three signals; oe low means this module drives
`default_nettype none
module pfc_host
   import pfc_pkg::*;
#(
   parameter int ADDR_WIDTH = pfc_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire pfc_pkg::pfc_req_s req,
   input wire logic hv_on_clear,
   input wire logic write_protect_en,
   input wire logic boost_en,
   output logic req_ready,
   output logic rsp_valid,
   output logic [pfc_pkg::DATA_W-1:0] rsp_data,
   output logic flash_busy,
   output pfc_pkg::pfc_pins_s pins,
   output logic write_protect_n,
   output logic boost_program_pin,
   output logic [pfc_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [pfc_pkg::DATA_W-1:0] dq_in,
   input wire logic done_flag_n
);
   import pfc_pkg::*;
   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_sync_b;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'h1};
      end
   end
   assign rst_sync_b = rst_sync_r[1];
   logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
   logic busy_s1_r, busy_s2_r;
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         dq_s1_r <= DATA_ZERO;
         dq_s2_r <= DATA_ZERO;
         busy_s1_r <= 1'h1;
         busy_s2_r <= 1'h1;
      end else if (clk_en) begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
         busy_s1_r <= done_flag_n;
         busy_s2_r <= busy_s1_r;
      end
   end
   // ----------------------------------------
   // bus sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      PFC_IDLE = 3'h0,
      PFC_SETUP = 3'h1,
      PFC_ACCESS = 3'h2,
      PFC_PULSE = 3'h3,
      PFC_RECOVER = 3'h4,
      PFC_CLEAR = 3'h5,
      PFC_WAIT = 3'h6
   } pfc_state_e;
   pfc_state_e st_r, st_nxt;
   pfc_req_s cur_r, cur_nxt;
   pfc_pins_s pins_r, pins_nxt;
   logic [DATA_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt;
   logic oe_r, oe_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
   logic [PAGE_BITS-1:0] beat_r, beat_nxt;
   logic ld;
   logic [CNT_W-1:0] ld_val;
   logic tdone;
   logic ctl_r, ctl_nxt;
   pfc_timer #(.W(CNT_W)) u_timer (
      .clk(clk),
      .rst_sync_b(rst_sync_b),
      .ce(clk_en),
      .load(ld),
      .value(ld_val),
      .done(tdone)
   );
   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      pins_nxt = pins_r;
      dq_nxt = dq_r;
      oe_nxt = oe_r;
      rd_nxt = rd_r;
      rv_nxt = 1'h0;
      rdy_nxt = rdy_r;
      beat_nxt = beat_r;
      ctl_nxt = ctl_r;
      ld = 1'h0;
      ld_val = '0;
      unique case (st_r)
         PFC_IDLE: begin
            // idle leaves select high so the flash sits in standby
            pins_nxt.sel_n = 1'h1;
            pins_nxt.gate_n = 1'h1;
            pins_nxt.strobe_n = 1'h1;
            pins_nxt.clear_hv = 1'h0;
            pins_nxt.gate_hv = 1'h0;
            pins_nxt.addr_ten_hv = 1'h0;
            oe_nxt = 1'h1;
            if (req_valid && rdy_r) begin
               cur_nxt = req;
               rdy_nxt = 1'h0;
               beat_nxt = '0;
               pins_nxt.addr = req.addr;
               st_nxt = PFC_SETUP;
               ld = 1'h1;
               ld_val = CNT_W'(1);
            end
         end
         PFC_SETUP: begin
            if (tdone) begin
               unique case (cur_r.op)
                  PFC_OP_RESET: begin
                     pins_nxt.clear_n = 1'h0;
                     ld_val = CNT_W'(RP_CYC);
                     st_nxt = PFC_CLEAR;
                  end
                  PFC_OP_WRITE, PFC_OP_PROTECT, PFC_OP_UNPROTECT: begin
                     pins_nxt.sel_n = 1'h0;
                     pins_nxt.gate_n = 1'h1;
                     oe_nxt = 1'h0;
                     dq_nxt = cur_r.wdata;
                     if (cur_r.op != PFC_OP_WRITE) begin
                        // bit seven picks protect or unprotect
                        // caller protects every group before unprotect
                        pins_nxt.addr = (cur_r.addr & ~BIT_SEVEN & ~BIT_ONE) | BIT_TWO
                           | ((cur_r.op == PFC_OP_UNPROTECT) ? BIT_SEVEN : '0);
                        // clear-pin method uses plain bus timing
                        pins_nxt.clear_hv = hv_on_clear;
                        pins_nxt.gate_hv = !hv_on_clear;
                        pins_nxt.addr_ten_hv = !hv_on_clear;
                     end
                     ld_val = CNT_W'(WP_CYC);
                     st_nxt = PFC_PULSE;
                  end
                  default: begin
                     // read, page and verify keep the strobe high
                     pins_nxt.sel_n = 1'h0;
                     pins_nxt.gate_n = 1'h0;
                     oe_nxt = 1'h1;
                     if (cur_r.op == PFC_OP_VERIFY) begin
                        pins_nxt.addr = (cur_r.addr & ~BIT_SEVEN & ~BIT_ONE) | BIT_TWO;
                        pins_nxt.addr_ten_hv = !hv_on_clear;
                     end
                     // fresh select always waits full access time
                     // two more cycles cover the dq synchroniser
                     ld_val = CNT_W'(((CE_CYC > ACC_CYC) ? CE_CYC : ACC_CYC) + 2);
                     st_nxt = PFC_ACCESS;
                  end
               endcase
               ld = 1'h1;
            end
         end
         PFC_PULSE: begin
            if (!ctl_r) begin
               pins_nxt.strobe_n = 1'h0;
               ctl_nxt = 1'h1;
               ld = 1'h1;
               ld_val = CNT_W'(WP_CYC);
            end else if (tdone) begin
               // strobe rise ends the write, protect or unprotect pulse
               pins_nxt.strobe_n = 1'h1;
               ctl_nxt = 1'h0;
               ld = 1'h1;
               ld_val = CNT_W'(1);
               st_nxt = PFC_RECOVER;
            end
         end
         PFC_ACCESS: begin
            if (tdone) begin
               rd_nxt = dq_s2_r;
               rv_nxt = 1'h1;
               if (cur_r.op == PFC_OP_VERIFY) begin
                  rd_nxt = dq_s2_r & PROTECT_BIT;
               end
               if (cur_r.op == PFC_OP_PAGE && beat_r != PAGE_BITS'(PAGE_WORDS - 1)) begin
                  // page held, in-page bits step, select kept low
                  beat_nxt = beat_r + PAGE_BITS'(1);
                  pins_nxt.addr[PAGE_BITS:1] = beat_r + PAGE_BITS'(1);
                  ld = 1'h1;
                  ld_val = CNT_W'(PAGE_CYC + 2);
               end else begin
                  pins_nxt.gate_n = 1'h1;
                  pins_nxt.sel_n = 1'h1;
                  pins_nxt.addr_ten_hv = 1'h0;
                  ld = 1'h1;
                  ld_val = CNT_W'(1);
                  st_nxt = PFC_RECOVER;
               end
            end
         end
         PFC_RECOVER: begin
            pins_nxt.sel_n = 1'h1;
            pins_nxt.clear_hv = 1'h0;
            pins_nxt.gate_hv = 1'h0;
            pins_nxt.addr_ten_hv = 1'h0;
            oe_nxt = 1'h1;
            if (tdone) begin
               rdy_nxt = 1'h1;
               st_nxt = PFC_IDLE;
            end
         end
         PFC_CLEAR: begin
            if (tdone) begin
               pins_nxt.clear_n = 1'h1;
               st_nxt = PFC_WAIT;
               ld = 1'h1;
               ld_val = CNT_W'(RH_CYC);
            end
         end
         PFC_WAIT: begin
            // wait for busy release and recovery before next read
            if (tdone && busy_s2_r) begin
               rdy_nxt = 1'h1;
               rv_nxt = 1'h1;
               st_nxt = PFC_IDLE;
            end
         end
         default: begin
            st_nxt = PFC_IDLE;
            rdy_nxt = 1'h1;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_r <= PFC_IDLE;
         cur_r <= '0;
         pins_r <= '{sel_n: 1'h1, gate_n: 1'h1, strobe_n: 1'h1, clear_n: 1'h1,
                     clear_hv: 1'h0, gate_hv: 1'h0, addr_ten_hv: 1'h0, addr: '0};
         dq_r <= DATA_ZERO;
         oe_r <= 1'h1;
         rd_r <= DATA_ZERO;
         rv_r <= 1'h0;
         rdy_r <= 1'h1;
         beat_r <= '0;
         ctl_r <= 1'h0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         pins_r <= pins_nxt;
         dq_r <= dq_nxt;
         oe_r <= oe_nxt;
         rd_r <= rd_nxt;
         rv_r <= rv_nxt;
         rdy_r <= rdy_nxt;
         beat_r <= beat_nxt;
         ctl_r <= ctl_nxt;
      end
   end
   // ----------------------------------------
   // static pins and status
   // ----------------------------------------
   logic wp_r, boost_r, busy_r;
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wp_r <= 1'h0;
         boost_r <= 1'h0;
         busy_r <= 1'h0;
      end else if (clk_en) begin
         wp_r <= !write_protect_en;
         boost_r <= boost_en;
         busy_r <= !busy_s2_r;
      end
   end
   assign req_ready = rdy_r;
   assign rsp_valid = rv_r;
   assign rsp_data = rd_r;
   assign flash_busy = busy_r;
   assign pins = pins_r;
   assign write_protect_n = wp_r;
   assign boost_program_pin = boost_r;
   assign dq_out = dq_r;
   assign dq_oe = oe_r;
endmodule : pfc_host
`default_nettype wire

// ---- logic/pfc_pkg.sv ----
// Purpose: constants and carriers for the parallel flash host controller
// Assumes: 40 MHz clk, word-mode flash bus with 21 address bits
// Notes: timing figures in ns, cycle counts derived from the clock period
`default_nettype none
package pfc_pkg;
   localparam int CLK_NS = 25;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int PAGE_WORDS = 4;
   localparam int PAGE_BITS = 2;
   localparam int BUF_WORDS = 16;
   localparam int ADDRESS_ACCESS_TIME_NS = 90;
   localparam int SELECT_ACCESS_TIME_NS = 90;
   localparam int PAGE_ACCESS_TIME_NS = 25;
   localparam int SLEEP_MARGIN_NS = 30;
   localparam int CLEAR_PULSE_MIN_NS = 500;
   localparam int CLEAR_TO_READ_TIME_NS = 50;
   localparam int WRITE_PULSE_NS = 50;
   localparam int CNT_W = 8;
   // least times round up
   localparam int ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int CE_CYC = (SELECT_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAGE_CYC = (PAGE_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_CYC = (ADDRESS_ACCESS_TIME_NS + SLEEP_MARGIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (CLEAR_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RH_CYC = (CLEAR_TO_READ_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [ADDR_W-1:0] BIT_TWO = 21'h000004;
   localparam logic [ADDR_W-1:0] BIT_ONE = 21'h000002;
   localparam logic [ADDR_W-1:0] BIT_SEVEN = 21'h000080;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] PROTECT_BIT = 16'h0001;
   typedef enum logic [2:0] {
      PFC_OP_READ = 3'h0,
      PFC_OP_WRITE = 3'h1,
      PFC_OP_PAGE = 3'h2,
      PFC_OP_PROTECT = 3'h3,
      PFC_OP_UNPROTECT = 3'h4,
      PFC_OP_VERIFY = 3'h5,
      PFC_OP_RESET = 3'h6
   } pfc_op_e;
   typedef struct packed {
      pfc_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pfc_req_s;
   typedef struct packed {
      logic sel_n;
      logic gate_n;
      logic strobe_n;
      logic clear_n;
      logic clear_hv;
      logic gate_hv;
      logic addr_ten_hv;
      logic [ADDR_W-1:0] addr;
   } pfc_pins_s;
endpackage : pfc_pkg
`default_nettype wire

// ---- logic/pfc_timer.sv ----
// Purpose: down counter for flash bus timing
// Assumes: load and count share the caller's clock enable
// Notes: done is high while the count is zero
`default_nettype none
module pfc_timer #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_sync_b,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = value;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
   end
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cnt_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end
   assign done = (cnt_r == '0);
endmodule : pfc_timer
`default_nettype wire

// ---- testbench/pfc_host_props.sv ----
// Purpose: port checks of the flash host controller
// Assumes: one clock, clk_en high
// Notes: own reset delay so checks wait for the design's copy
`default_nettype none
module pfc_host_props
   import pfc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic write_protect_en,
   input wire logic boost_en,
   input wire pfc_pkg::pfc_pins_s pins,
   input wire logic write_protect_n,
   input wire logic boost_program_pin,
   input wire logic dq_oe,
   input wire logic done_flag_n,
   input wire logic flash_busy
);
   logic [2:0] ok_r, ok_nxt;
   logic [7:0] low_r, low_nxt;
   always_comb begin
      ok_nxt = {ok_r[1:0], 1'b1};
      low_nxt = pins.clear_n ? 8'h00 : low_r + 8'h01;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ok_r <= 3'h0;
         low_r <= 8'h00;
      end else begin
         ok_r <= ok_nxt;
         low_r <= low_nxt;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!ok_r[2]);
   sequence sel_read;
      $fell(pins.sel_n) && !pins.gate_n;
   endsequence
   sequence busy_seen;
      (!done_flag_n) [*4];
   endsequence
   AST_READ_PINS: assert property (!pins.sel_n && !pins.gate_n |-> pins.strobe_n)
      else $error("strobe low in read");
   AST_WRITE_PINS: assert property (!pins.strobe_n |-> !pins.sel_n && pins.gate_n)
      else $error("bad write pins");
   AST_DQ_FLOAT: assert property (!dq_oe |-> pins.gate_n)
      else $error("dq driven in read");
   AST_HV_PAIR: assert property (pins.gate_hv |-> pins.addr_ten_hv)
      else $error("gate hv alone");
   AST_WP_PIN: assert property (clk_en |=> write_protect_n == !$past(write_protect_en))
      else $error("write protect pin");
   AST_BOOST_PIN: assert property (clk_en |=> boost_program_pin == $past(boost_en))
      else $error("boost pin");
   AST_CLEAR_WIDTH: assert property ($rose(pins.clear_n) |-> low_r >= 8'(RP_CYC))
      else $error("clear pulse short");
   AST_GATE_HOLD: assert property (sel_read |-> (!pins.gate_n && !pins.sel_n) [*4])
      else $error("read access short");
   AST_BUSY_FLAG: assert property (busy_seen |-> flash_busy)
      else $error("busy not shown");
endmodule : pfc_host_props
bind pfc_host pfc_host_props chk_i (.clk, .rst_b, .clk_en, .write_protect_en, .boost_en, .pins,
   .write_protect_n, .boost_program_pin, .dq_oe, .done_flag_n, .flash_busy);
`default_nettype wire

// ---- testbench/pfc_flash_model.sv ----
// Purpose: behavioural nor flash behind the host controller
// Assumes: groups on addr bits 20:17
// Notes: released data lines show the inverse of the last word
`default_nettype none
module pfc_flash_model
   import pfc_pkg::*;
#(
   parameter logic [15:0] MAKER_ID = 16'h005A, // arbitrary code
   parameter int BUSY_NS = 2000,
   parameter int READY_NS = 1000
) (
   input wire pfc_pkg::pfc_pins_s pins,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   input wire logic write_protect_n,
   input wire logic boost_program_pin,
   output logic [15:0] dq_in,
   output logic done_flag_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic [15:0] prot = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic [15:0] val, pd;
   logic [19:0] kf, kf_d;
   logic [1:0] ki_d;
   logic [7:0] pa;
   logic idm = 1'b0; // array read from power-up
   logic ok;
   int step = 0;
   int left = 0;
   wire [20:0] a = pins.addr;
   wire [3:0] grp = a[20:17]; // four sectors share one bit
   wire hv = pins.addr_ten_hv || idm;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'hC000 + 16'(i);
   assign kf = {pins.sel_n, a[20:3], a[0]};
   assign #90 kf_d = kf; // full time after reselect
   assign #25 ki_d = a[2:1]; // fast in-page access
   assign ok = !pins.sel_n && !pins.gate_n && pins.strobe_n && pins.clear_n
      && kf_d === kf && ki_d === a[2:1];
   always_comb begin
      if (hv && a[2]) val = {15'h0000, prot[grp]};
      else if (hv) val = MAKER_ID;
      else val = mem[a[7:0]];
   end
   always @(val or ok) if (ok) last = val; // word held while address stands
   assign dq_in = !dq_oe ? dq_out : ok ? val : ~last;
   assign done_flag_n = (left == 0);
   always #10 begin
      if (left > 0) left -= 10;
      if (left == 0 && pa !== 8'hxx) mem[pa] = pd;
      if (left == 0) pa = 8'hxx;
   end
   always @(negedge pins.clear_n) begin // abort, back to array read
      if (left > 0) left = READY_NS;
      pa = 8'hxx;
      idm = 0;
      step = 0;
   end
   always @(negedge pins.strobe_n) begin
      if (!pins.sel_n && (pins.clear_hv || pins.gate_hv && pins.addr_ten_hv)) begin
         if (a[7]) prot = 16'h0000;
         else prot[grp] = 1'b1;
      end
   end
   always @(posedge pins.strobe_n) begin
      if (!pins.sel_n && pins.gate_n && pins.clear_n && !pins.clear_hv && !pins.gate_hv) begin
         if (step == 3 && left == 0 && write_protect_n && (boost_program_pin || !prot[grp])) begin
            pa = a[7:0];
            pd = dq_out;
            left = BUSY_NS;
         end
         if (step == 3) step = 0;
         else if (step == 0 && boost_program_pin && dq_out == 16'h00A0) step = 3;
         else if (step == 0 && a == 21'h000555 && dq_out == 16'h00AA) step = 1;
         else if (step == 1 && a == 21'h0002AA && dq_out == 16'h0055) step = 2;
         else if (step == 2 && dq_out == 16'h00A0) step = 3;
         else begin
            idm = (step == 2 && dq_out == 16'h0090);
            step = 0;
         end
      end
   end
endmodule : pfc_flash_model
`default_nettype wire

// ---- testbench/test_pfc_host.sv ----
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the far side
// Notes: watchdog span is over twenty times the whole run
`default_nettype none
module test_pfc_host;
   timeunit 1ns;
   timeprecision 1ps;
   import pfc_pkg::*;
   localparam logic [15:0] ID = 16'h005A; // arbitrary code
   logic clk = 0;
   logic rst_b = 0;
   logic clk_en = 1;
   logic req_valid = 0;
   logic hv_on_clear = 0;
   logic write_protect_en = 0;
   logic boost_en = 0;
   pfc_req_s req = '0;
   logic req_ready, rsp_valid, flash_busy, write_protect_n, boost_program_pin, dq_oe, done_flag_n;
   logic [15:0] rsp_data, dq_out, dq_in, v;
   pfc_pins_s pins;
   int failures = 0;
   int tests_run = 0;
   always #12.5 clk = ~clk;
   pfc_host uut (.clk, .rst_b, .clk_en, .req_valid, .req, .hv_on_clear, .write_protect_en,
      .boost_en, .req_ready, .rsp_valid, .rsp_data, .flash_busy, .pins, .write_protect_n,
      .boost_program_pin, .dq_out, .dq_oe, .dq_in, .done_flag_n);
   pfc_flash_model #(.MAKER_ID(ID)) fm (.pins, .dq_out, .dq_oe, .write_protect_n,
      .boost_program_pin, .dq_in, .done_flag_n);
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic issue(pfc_op_e op, logic [20:0] a, logic [15:0] d);
      int n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 4000);
      req_valid <= 1'b0;
   endtask : issue
   task automatic get;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 4000);
      v = rsp_data;
   endtask : get
   task automatic rd(logic [20:0] a, logic [15:0] exp);
      issue(PFC_OP_READ, a, 16'h0000);
      get;
      chk(v, exp);
   endtask : rd
   task automatic unlock(logic [15:0] d);
      issue(PFC_OP_WRITE, 21'h000555, 16'h00AA);
      issue(PFC_OP_WRITE, 21'h0002AA, 16'h0055);
      issue(PFC_OP_WRITE, 21'h000555, d);
   endtask : unlock
   task automatic settle;
      for (int n = 0; n < 400; n++) begin
         @(posedge clk);
         if (n > 16 && flash_busy === 1'b0 && req_ready === 1'b1) break;
      end
   endtask : settle
   task automatic prog(logic [20:0] a, logic [15:0] d);
      unlock(16'h00A0);
      issue(PFC_OP_WRITE, a, d);
      settle;
   endtask : prog
   task automatic t_read_page;
      rd(21'h000013, 16'hC013);
      issue(PFC_OP_PAGE, 21'h000040, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         get;
         chk(v, 16'hC040 + 16'(2 * i));
      end
      $display("test read and page done");
   endtask : t_read_page
   task automatic t_cmd;
      prog(21'h000066, 16'h1234);
      rd(21'h000066, 16'h1234);
      unlock(16'h0090);
      rd(21'h000000, ID);
      issue(PFC_OP_WRITE, 21'h000555, 16'h0077);
      rd(21'h000013, 16'hC013);
      $display("test commands done");
   endtask : t_cmd
   task automatic t_prot;
      issue(PFC_OP_PROTECT, 21'h060000, 16'h0000);
      issue(PFC_OP_VERIFY, 21'h060000, 16'h0000);
      get;
      chk(v, 16'h0001);
      unlock(16'h0090);
      rd(21'h060004, 16'h0001);
      issue(PFC_OP_WRITE, 21'h000555, 16'h00F0);
      prog(21'h060011, 16'h0BAD);
      rd(21'h060011, 16'hC011);
      @(posedge clk);
      boost_en <= 1'b1;
      issue(PFC_OP_WRITE, 21'h000555, 16'h00A0);
      issue(PFC_OP_WRITE, 21'h060022, 16'h0BAD);
      settle;
      rd(21'h060022, 16'h0BAD);
      boost_en <= 1'b0;
      hv_on_clear <= 1'b1;
      issue(PFC_OP_UNPROTECT, 21'h060080, 16'h0000);
      // verify needs the bit-ten method, else it reads the array
      repeat (3) @(posedge clk);
      hv_on_clear <= 1'b0;
      issue(PFC_OP_VERIFY, 21'h060000, 16'h0000);
      get;
      chk(v, 16'h0000);
      $display("test protect done");
   endtask : t_prot
   task automatic t_wp_clear;
      @(posedge clk);
      write_protect_en <= 1'b1;
      prog(21'h000077, 16'h5555);
      rd(21'h000077, 16'hC077);
      write_protect_en <= 1'b0;
      unlock(16'h00A0);
      issue(PFC_OP_WRITE, 21'h000088, 16'h4321);
      issue(PFC_OP_RESET, 21'h000000, 16'h0000);
      repeat (8) @(posedge clk);
      chk({15'h0000, flash_busy}, 16'h0001);
      get;
      rd(21'h000088, 16'hC088);
      $display("test protect pin and clear done");
   endtask : t_wp_clear
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_read_page;
      t_cmd;
      t_prot;
      t_wp_clear;
      report_and_stop;
   end
   initial begin
      #(400000);
      failures++;
      report_and_stop;
   end
endmodule : test_pfc_host
`default_nettype wire
